// File: hw/soft_limit_params.svh
// register offsets, field positions and reset values of the soft limit block
`ifndef SOFT_LIMIT_PARAMS_SVH
`define SOFT_LIMIT_PARAMS_SVH
`define SL_OFF_COUNT   12'h000
`define SL_OFF_LOWER   12'h004
`define SL_OFF_UPPER   12'h008
`define SL_OFF_HOMEOFS 12'h00c
`define SL_OFF_STATUS  12'h010
`define SL_COUNT_VAL   8'h00
`define SL_RST_LIMIT   32'h00000000
`define SL_ST_ACTIVE   0
`define SL_ST_HOMED    1
`define SL_ST_CLAMPLO  2
`define SL_ST_CLAMPHI  3
`endif

// File: hw/soft_limit_pkg.sv
// types of the soft limit block
package soft_limit_pkg;
  typedef enum logic [1:0] {
    CLAMP_NONE = 2'b01,
    CLAMP_SAT  = 2'b10
  } clamp_mode_t;
endpackage : soft_limit_pkg

// File: hw/limit_bus_if.sv
// bound set passed from the register side to the comparator
`timescale 1ns/100ps
`default_nettype none
interface limit_bus_if #(parameter int W = 32);
  logic signed [W-1:0] lower;
  logic signed [W-1:0] upper;
  logic                active;
  modport src (output lower, output upper, output active);
  modport dst (input lower, input upper, input active);
endinterface : limit_bus_if
`default_nettype wire

// File: hw/limit_clamp.sv
// comparator that saturates a target against the active bounds
`timescale 1ns/100ps
`default_nettype none
module limit_clamp #(
  parameter int W = 32
) (
  limit_bus_if.dst           lim,
  input  wire logic signed [W-1:0] target,
  output logic signed [W-1:0]      result,
  output logic                     below,
  output logic                     above
);
  always_comb begin
    below  = lim.active && (target < lim.lower);   // [R01]
    above  = lim.active && (target > lim.upper);   // [R01]
    result = target;
    if (below) begin
      result = lim.lower;   // [R05]
    end else if (above) begin
      result = lim.upper;   // [R05]
    end
  end
endmodule : limit_clamp
`default_nettype wire

// File: hw/software_position_limit.sv
// software position limit: apb registers, bound selection, target clamping
//
// Functional notes
// [R01] check every target against active bounds; the code drops targets that arrive while clk_en is low
// [R02] bounds are limits minus home offset
// [R03] homed: use corrected bounds only if lower<upper
// [R04] unhomed: raw limits only if lower<upper
// [R05] saturate violating target to crossed bound
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "soft_limit_params.svh"
module software_position_limit
  import soft_limit_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                homing_done,
  input  wire logic                target_valid,
  input  wire logic signed [W-1:0] target_pos,
  output logic                     cmd_valid,
  output logic signed [W-1:0]      cmd_pos,
  output logic                     cmd_clamped
);
  initial begin
    if (W != 32) $error("software_position_limit supports only W = 32");
  end

  typedef struct packed {
    logic signed [31:0] lower;
    logic signed [31:0] upper;
    logic signed [31:0] home_ofs;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic               cmd_valid;
    logic signed [31:0] cmd_pos;
    logic               cmd_clamped;
    logic               hit_lo;
    logic               hit_hi;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  limit_bus_if #(.W(W)) lim ();

  logic signed [W-1:0] clamp_out;
  logic                clamp_lo;
  logic                clamp_hi;
  logic signed [W-1:0] corr_lo;
  logic signed [W-1:0] corr_hi;
  clamp_mode_t         mode;

  // corrected bounds wrap in two's complement, like the drive's own arithmetic
  assign corr_lo = st_ff.lower - st_ff.home_ofs;   // [R02]
  assign corr_hi = st_ff.upper - st_ff.home_ofs;   // [R02]

  always_comb begin
    if (homing_done) begin
      lim.lower  = corr_lo;   // [R03]
      lim.upper  = corr_hi;
      mode       = (corr_lo < corr_hi) ? CLAMP_SAT : CLAMP_NONE;   // [R03]
    end else begin
      lim.lower  = st_ff.lower;   // [R04]
      lim.upper  = st_ff.upper;
      mode       = (st_ff.lower < st_ff.upper) ? CLAMP_SAT : CLAMP_NONE;   // [R04]
    end
    lim.active = (mode == CLAMP_SAT);
  end

  limit_clamp #(.W(W)) u_clamp (
    .lim    (lim),
    .target (target_pos),
    .result (clamp_out),
    .below  (clamp_lo),
    .above  (clamp_hi)
  );

  logic apb_acc;
  assign apb_acc = psel && penable && !st_ff.pready;

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.pready    = 1'b0;
    nxt_st.pslverr   = 1'b0;
    nxt_st.cmd_valid = target_valid;
    // one result per target taken while clk_en is high, registered so outputs come from flip-flops
    if (target_valid) begin
      nxt_st.cmd_pos     = clamp_out;   // [R01] [R05]
      nxt_st.cmd_clamped = clamp_lo || clamp_hi;
      nxt_st.hit_lo      = clamp_lo;
      nxt_st.hit_hi      = clamp_hi;
    end
    // one wait state: answer in the cycle after the first access cycle
    if (apb_acc) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h00000000;
      unique case (paddr)
        `SL_OFF_COUNT: begin
          if (pwrite) begin
            nxt_st.pslverr = 1'b1;
          end else begin
            nxt_st.prdata = {24'h000000, `SL_COUNT_VAL};
          end
        end
        `SL_OFF_LOWER: begin
          if (pwrite) begin
            nxt_st.lower = pwdata;
          end else begin
            nxt_st.prdata = st_ff.lower;
          end
        end
        `SL_OFF_UPPER: begin
          if (pwrite) begin
            nxt_st.upper = pwdata;
          end else begin
            nxt_st.prdata = st_ff.upper;
          end
        end
        `SL_OFF_HOMEOFS: begin
          if (pwrite) begin
            nxt_st.home_ofs = pwdata;
          end else begin
            nxt_st.prdata = st_ff.home_ofs;
          end
        end
        `SL_OFF_STATUS: begin
          if (pwrite) begin
            nxt_st.pslverr = 1'b1;
          end else begin
            nxt_st.prdata[`SL_ST_ACTIVE]  = lim.active;
            nxt_st.prdata[`SL_ST_HOMED]   = homing_done;
            nxt_st.prdata[`SL_ST_CLAMPLO] = st_ff.hit_lo;
            nxt_st.prdata[`SL_ST_CLAMPHI] = st_ff.hit_hi;
          end
        end
        default: begin
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.lower    <= `SL_RST_LIMIT;
      st_ff.upper    <= `SL_RST_LIMIT;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata      = st_ff.prdata;
  assign pready      = st_ff.pready;
  assign pslverr     = st_ff.pslverr;
  assign cmd_valid   = st_ff.cmd_valid;
  assign cmd_pos     = st_ff.cmd_pos;
  assign cmd_clamped = st_ff.cmd_clamped;
endmodule : software_position_limit
`default_nettype wire

// File: test/spl_assertions.sv
// port checker of the position limit block
`timescale 1ns/100ps
`default_nettype none
module spl_chk #(parameter int W = 32) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                clk_en,
  input wire logic                target_valid,
  input wire logic signed [W-1:0] target_pos,
  input wire logic                cmd_valid,
  input wire logic signed [W-1:0] cmd_pos,
  input wire logic                cmd_clamped
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_once_a: assert property (target_valid && clk_en |=> cmd_valid)
    else $error("target lost");
  answer_cause_a: assert property (cmd_valid |-> $past(target_valid) || !$past(clk_en))
    else $error("stray answer");
  pass_thru_a: assert property (cmd_valid && !cmd_clamped && $past(clk_en)
    |-> cmd_pos == $past(target_pos))
    else $error("target altered");
  clamp_moves_a: assert property (cmd_valid && cmd_clamped && $past(clk_en)
    |-> cmd_pos != $past(target_pos))
    else $error("clamp flag wrong");
  pos_hold_a: assert property (!$past(target_valid) |-> $stable(cmd_pos))
    else $error("command moved");
  cover property (cmd_valid && cmd_clamped);
  cover property (cmd_valid && !cmd_clamped);
  cover property (target_valid [*2]);
endmodule : spl_chk
bind software_position_limit spl_chk #(.W(W)) chk_u (.pclk, .presetn, .clk_en, .target_valid,
  .target_pos, .cmd_valid, .cmd_pos, .cmd_clamped);
`default_nettype wire

// File: test/target_host_model.sv
// host controller model issuing target positions
`timescale 1ns/100ps
`default_nettype none
module target_host_model (
  input  wire logic          pclk,
  output logic               target_valid,
  output logic signed [31:0] target_pos
);
  initial begin
    target_valid = 1'b0;
    target_pos = 32'sh0;
  end
  task automatic send(input logic signed [31:0] p);
    @(posedge pclk);
    target_valid <= 1'b1;
    target_pos <= p;
    @(posedge pclk);
    target_valid <= 1'b0;
    target_pos <= ~p; // idle bus shows junk, not the last value
  endtask : send
endmodule : target_host_model
`default_nettype wire

// File: test/software_position_limit_tb.sv
// self-checking bench of the position limit block
`timescale 1ns/100ps
`default_nettype none
`include "soft_limit_params.svh"
module software_position_limit_tb;
  import soft_limit_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, homing_done = 0, clk_en = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, target_valid, cmd_valid, cmd_clamped;
  logic signed [31:0] target_pos, cmd_pos;
  int bad_count = 0, n_compared = 0, cyc = 0;
  always #10 pclk = ~pclk;
  target_host_model host_u (.pclk, .target_valid, .target_pos);
  software_position_limit dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .homing_done, .target_valid, .target_pos,
    .cmd_valid, .cmd_pos, .cmd_clamped);
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (!pready && n < 50);
    if (!pready) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tgt(input logic signed [31:0] p, e, input logic c);
    host_u.send(p);
    #1;
    chk(cmd_valid, 1'b1);
    chk(cmd_pos, e);
    chk(cmd_clamped, c);
    @(posedge pclk);
    #1;
    chk(cmd_valid, 1'b0);
  endtask : tgt
  task automatic t_regs;
    apb(0, `SL_OFF_COUNT, 0); chk(rd, {24'h000000, `SL_COUNT_VAL});
    apb(1, `SL_OFF_COUNT, 5); chk(err, 1'b1);
    apb(0, 12'h0f0, 0); chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1, `SL_OFF_LOWER, -100);
    apb(1, `SL_OFF_UPPER, 100);
    apb(0, `SL_OFF_LOWER, 0); chk(rd, -100);
    $display("registers done");
  endtask : t_regs
  task automatic t_unhomed;
    tgt(-200, -100, 1);
    tgt(300, 100, 1);
    tgt(100, 100, 0);
    apb(1, `SL_OFF_UPPER, -100);
    tgt(300, 300, 0);
    $display("unhomed done");
  endtask : t_unhomed
  task automatic t_homed;
    apb(1, `SL_OFF_HOMEOFS, 50);
    apb(1, `SL_OFF_UPPER, 100);
    homing_done <= 1'b1;
    tgt(60, 50, 1);
    tgt(-200, -150, 1);
    apb(0, `SL_OFF_STATUS, 0); chk(rd[3:0], 4'h7);
    tgt(-120, -120, 0);
    apb(0, `SL_OFF_STATUS, 0); chk(rd[3:0], 4'h3);
    apb(1, `SL_OFF_LOWER, 200);
    tgt(999, 999, 0);
    $display("homed done");
  endtask : t_homed
  task automatic t_freeze;
    @(posedge pclk);
    clk_en <= 1'b0;
    host_u.send(500);
    #1;
    chk(cmd_valid, 1'b0);
    chk(cmd_pos, 999);
    @(posedge pclk);
    clk_en <= 1'b1;
    $display("freeze done");
  endtask : t_freeze
  task automatic t_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(cmd_pos, 0);
    chk(cmd_clamped, 1'b0);
    apb(0, `SL_OFF_LOWER, 0); chk(rd, 32'h0);
    tgt(-5, -5, 0);
    $display("reset done");
  endtask : t_reset
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_unhomed();
    t_homed();
    t_freeze();
    t_reset();
    results();
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
endmodule : software_position_limit_tb
`default_nettype wire
